// >>> hw/pwr_state_pkg.sv
package pwr_state_pkg;

  // Power-state sequencer states
  typedef enum logic [2:0] {
    ST_RUN      = 3'h0,  // Normal execution
    ST_SMM_SAVE = 3'h1,  // Waiting for core to save execution state
    ST_SMM_ACK  = 3'h2,  // Management acknowledge pending on system bus
    ST_SMM_EXEC = 3'h3,  // Running the management handler
    ST_SG_ACK   = 3'h4,  // Stop-Grant acknowledge pending on system bus
    ST_SG       = 3'h5   // Stop-Grant: core clocks gated
  } pwr_state_e;

  // Kind of acknowledge transaction handed to the bus unit
  typedef enum logic [0:0] {
    ACK_SMM       = 1'h0,  // Management-interrupt acknowledge
    ACK_STOPGRANT = 1'h1   // Stop-Grant acknowledge
  } ack_kind_e;

  // Acknowledge request towards the bus unit
  typedef struct packed {
    logic      valid;  // Request stands until taken
    ack_kind_e kind;   // Which acknowledge to issue
  } ack_req_s;

  // Clock-enable group for the unit clock gates
  typedef struct packed {
    logic core;  // All core units
    logic bus;   // Bus unit
    logic apic;  // Interrupt controller unit
  } clk_en_s;

  // Complete state of the control block
  typedef struct packed {
    pwr_state_e fsm;          // Sequencer state
    logic [1:0] smi_sync;     // Management request synchroniser, [0] first stage
    logic [1:0] stp_sync;     // Clock-stop request synchroniser
    logic [1:0] hot_sync;     // Sensor trip synchroniser
    logic       smi_prev;     // Synchronised request, one cycle old
    logic       smi_pend;     // Request seen and not yet accepted
    logic       mgmt_mode;    // Management mode active
    logic       trip;         // Latched over-temperature trip
    logic       trip_n;       // Registered trip pin, low when tripped
    logic       save_req;     // Ask core to save execution state
    ack_req_s   ack;          // Acknowledge request to bus unit
    logic       fetch_go;     // One-cycle start of handler fetch
    clk_en_s    clk_en;       // Unit clock enables
    logic       halt;         // Execution halted
  } ctl_s;

  // Value after reset: running, clocks on, nothing pending
  localparam ctl_s CTL_RESET = '{
    fsm:       ST_RUN,
    smi_sync:  2'h3,  // Idle high, no false request at release
    stp_sync:  2'h3,  // Idle high, no false clock-stop at release
    hot_sync:  2'h0,
    smi_prev:  1'h0,
    smi_pend:  1'h0,
    mgmt_mode: 1'h0,
    trip:      1'h0,
    trip_n:    1'h1,
    save_req:  1'h0,
    ack:       '{valid: 1'h0, kind: ACK_SMM},
    fetch_go:  1'h0,
    clk_en:    '{core: 1'h1, bus: 1'h1, apic: 1'h1},
    halt:      1'h0
  };

endpackage : pwr_state_pkg

// >>> hw/pwr_state_ctl.sv
// Contract
// - Accepted request saves state, enters management mode.
// - Then issue management acknowledge on bus.
// - After acknowledge, start fetching handler code.
// - Clock-stop request enters Stop-Grant, issues acknowledge.
// - Stop-Grant gates core clocks; bus, interrupt kept.
// - Stop-Grant keeps snooping and servicing interrupts.
// - Clock-stop release restarts clocks, resumes execution.
// - Clock-stop is asynchronous; bus clock untouched.
// - Over-temperature halts execution, asserts trip output.
// - Trip output latched, halted until reset.
// - No hysteresis; cool reset resumes execution.
// - Still hot at reset keeps trip asserted; here the pin rises during reset and falls again three edges after release.
`timescale 1ns/10ps
module pwr_state_ctl (
  input  wire logic                  clk,              // Bus reference clock, 50 MHz
  input  wire logic                  rst_n,            // Asynchronous reset, active low
  input  wire logic                  sys_mgmt_irq_n,   // Management request, async, active low
  input  wire logic                  clock_stop_req_n, // Clock-stop request, async, active low
  input  wire logic                  temp_over,        // Sensor comparator, high above trip level
  input  wire logic                  save_done,        // Core finished saving state
  input  wire logic                  ack_taken,        // Bus unit took the acknowledge
  input  wire logic                  mgmt_exit,        // Core leaves management mode
  output logic                       sys_mgmt_mode,    // Management mode active
  output logic                       state_save_req,   // Save execution state request
  output pwr_state_pkg::ack_req_s    ack_req,          // Acknowledge request to bus unit
  output logic                       handler_fetch,    // One-cycle start of handler fetch
  output pwr_state_pkg::clk_en_s     unit_clk_en,      // Unit clock enables
  output logic                       exec_halt,        // Execution halted
  output logic                       overtemp_trip_n   // Thermal trip pin, active low
);

  pwr_state_pkg::ctl_s cur;       // Registered state
  pwr_state_pkg::ctl_s next_cur;  // Next state

  logic smi_act;   // Synchronised management request, active high
  logic stp_act;   // Synchronised clock-stop request, active high
  logic hot;       // Synchronised sensor trip

  // Request synchronisers reset to the idle high level of their pins, so the
  // edge detector and the clock-stop decode see no false request at release.
  // Pins must still sit high through reset for that to hold.

  // Only second stages are read by logic
  assign smi_act = ~cur.smi_sync[1];
  assign stp_act = ~cur.stp_sync[1];
  assign hot     = cur.hot_sync[1];

  // Next-state logic for the whole block
  // One sequence runs at a time; the trip check at the end overrides
  // whatever the sequencer decided in the same cycle, except a mode entry or exit on mgmt_mode
  always_comb begin
    next_cur = cur;
    next_cur.smi_sync = {cur.smi_sync[0], sys_mgmt_irq_n};
    next_cur.stp_sync = {cur.stp_sync[0], clock_stop_req_n};
    // Sensor sits on another timing domain, so it is synchronised too
    next_cur.hot_sync = {cur.hot_sync[0], temp_over};
    next_cur.smi_prev = smi_act;
    next_cur.fetch_go = 1'h0;
    // catch request edge, set wins over clear
    if (smi_act && !cur.smi_prev) begin
      next_cur.smi_pend = 1'h1;
    end
    // Mode bit drops when the handler returns
    if (mgmt_exit && cur.fsm == pwr_state_pkg::ST_SMM_EXEC) begin
      next_cur.mgmt_mode = 1'h0;
    end

    case (cur.fsm)
      pwr_state_pkg::ST_RUN, pwr_state_pkg::ST_SMM_EXEC: begin
        // Management request outranks clock-stop; none nested in handler
        if (cur.smi_pend && cur.fsm == pwr_state_pkg::ST_RUN) begin
          next_cur.smi_pend = smi_act && !cur.smi_prev;
          next_cur.save_req = 1'h1;
          next_cur.fsm      = pwr_state_pkg::ST_SMM_SAVE;
        end else if (stp_act) begin
          next_cur.ack = '{valid: 1'h1, kind: pwr_state_pkg::ACK_STOPGRANT};
          next_cur.fsm = pwr_state_pkg::ST_SG_ACK;
        end else if (mgmt_exit && cur.fsm == pwr_state_pkg::ST_SMM_EXEC) begin
          next_cur.fsm = pwr_state_pkg::ST_RUN;
        end
      end
      pwr_state_pkg::ST_SMM_SAVE: begin
        // Core may take any number of cycles to save
        // enter management mode once state is saved
        if (save_done) begin
          next_cur.save_req  = 1'h0;
          next_cur.mgmt_mode = 1'h1;
          next_cur.ack = '{valid: 1'h1, kind: pwr_state_pkg::ACK_SMM};
          next_cur.fsm = pwr_state_pkg::ST_SMM_ACK;
        end
      end
      pwr_state_pkg::ST_SMM_ACK: begin
        // Request stands while the bus unit stalls
        if (ack_taken) begin
          next_cur.ack.valid = 1'h0;
          next_cur.fetch_go = 1'h1;
          next_cur.fsm      = pwr_state_pkg::ST_SMM_EXEC;
        end
      end
      pwr_state_pkg::ST_SG_ACK: begin
        // Core keeps running until the acknowledge is on the bus
        if (ack_taken) begin
          next_cur.ack.valid = 1'h0;
          // gate core clocks only after acknowledge left
          next_cur.clk_en.core = 1'h0;
          next_cur.fsm         = pwr_state_pkg::ST_SG;
        end
      end
      pwr_state_pkg::ST_SG: begin
        if (!stp_act) begin
          next_cur.clk_en.core = 1'h1;
          next_cur.fsm = cur.mgmt_mode ? pwr_state_pkg::ST_SMM_EXEC : pwr_state_pkg::ST_RUN;
        end
      end
      default: begin
        // Unused encodings recover to normal execution
        next_cur.fsm = pwr_state_pkg::ST_RUN;
      end
    endcase

    // bus and interrupt units never gated
    // so snoops and interrupts continue in Stop-Grant
    // bus clock itself is never touched here
    next_cur.clk_en.bus  = 1'h1;
    next_cur.clk_en.apic = 1'h1;

    // trip halts everything and wins over all sequencing except mode entry or exit on mgmt_mode
    // latch holds, only reset clears it
    // Pending requests are dropped: a stopped core cannot serve them
    if (hot || cur.trip) begin
      next_cur.trip        = 1'h1;
      next_cur.trip_n      = 1'h0;
      next_cur.halt        = 1'h1;
      next_cur.clk_en.core = 1'h0;
      next_cur.save_req    = 1'h0;
      next_cur.ack.valid   = 1'h0;
      next_cur.fetch_go    = 1'h0;
      next_cur.smi_pend    = 1'h0;
      next_cur.fsm         = pwr_state_pkg::ST_RUN;
    end
  end

  // State register
  // reset clears latch; still hot re-trips after sync delay
  // Limitation: the reset branch loads constants only, so the trip pin
  // rises during reset and falls again three edges after release if still hot
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur <= pwr_state_pkg::CTL_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  // Outputs straight from flops
  // No output passes through logic, so none can glitch
  assign sys_mgmt_mode   = cur.mgmt_mode;
  assign state_save_req  = cur.save_req;
  assign ack_req         = cur.ack;
  assign handler_fetch   = cur.fetch_go;
  assign unit_clk_en     = cur.clk_en;
  assign exec_halt       = cur.halt;
  assign overtemp_trip_n = cur.trip_n;

  // Assertions
  // Each one names the rule it guards; reset disables them all
  AST_SAVE_BEFORE_MODE: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(cur.mgmt_mode) |-> $past(cur.fsm) == pwr_state_pkg::ST_SMM_SAVE && $past(save_done))
    else $error("Management mode entered without saved state");

  AST_ACK_AFTER_MODE: assert property (@(posedge clk) disable iff (!rst_n)
    ($rose(cur.ack.valid) && cur.ack.kind == pwr_state_pkg::ACK_SMM) |-> cur.mgmt_mode)
    else $error("Management acknowledge before mode entry");

  AST_FETCH_AFTER_ACK: assert property (@(posedge clk) disable iff (!rst_n)
    handler_fetch |-> $past(cur.fsm) == pwr_state_pkg::ST_SMM_ACK && $past(ack_taken) && !ack_req.valid)
    else $error("Handler fetch without acknowledge");

  AST_SG_ACK: assert property (@(posedge clk) disable iff (!rst_n)
    (cur.fsm == pwr_state_pkg::ST_RUN && !cur.smi_pend && stp_act && !hot && !cur.trip)
      |=> ack_req.valid && ack_req.kind == pwr_state_pkg::ACK_STOPGRANT)
    else $error("Clock-stop did not raise Stop-Grant acknowledge");

  AST_SG_GATE: assert property (@(posedge clk) disable iff (!rst_n)
    cur.fsm == pwr_state_pkg::ST_SG |-> !unit_clk_en.core && unit_clk_en.bus && unit_clk_en.apic)
    else $error("Stop-Grant clock gating wrong");

  AST_SG_EXIT: assert property (@(posedge clk) disable iff (!rst_n)
    (cur.fsm == pwr_state_pkg::ST_SG && !stp_act && !hot && !cur.trip) |=> unit_clk_en.core && cur.fsm != pwr_state_pkg::ST_SG)
    else $error("Clock-stop release did not restart clocks");

  AST_TRIP_SET: assert property (@(posedge clk) disable iff (!rst_n)
    hot |=> !overtemp_trip_n && exec_halt && !unit_clk_en.core)
    else $error("Trip not asserted when hot");

  AST_TRIP_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    !overtemp_trip_n |=> !overtemp_trip_n && exec_halt)
    else $error("Trip latch released without reset");

  AST_TRIP_LATENCY: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(temp_over) |-> ##[1:3] !overtemp_trip_n)
    else $error("Trip slower than synchroniser delay");

  AST_SYNC_DELAY: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(cur.stp_sync[1]) |-> $past(clock_stop_req_n, 2) == 1'h0)
    else $error("Clock-stop bypassed synchroniser");

  COV_SMM_ENTRY: cover property (@(posedge clk) disable iff (!rst_n) $rose(handler_fetch));
  COV_SG_ROUND:  cover property (@(posedge clk) disable iff (!rst_n)
    cur.fsm == pwr_state_pkg::ST_SG ##1 cur.fsm == pwr_state_pkg::ST_RUN);
  COV_TRIP:      cover property (@(posedge clk) disable iff (!rst_n) $fell(overtemp_trip_n));
  COV_SG_IN_SMM: cover property (@(posedge clk) disable iff (!rst_n)
    cur.fsm == pwr_state_pkg::ST_SG && cur.mgmt_mode);

endmodule : pwr_state_ctl

// >>> tb/chipset_model.sv
`timescale 1ns/10ps
module chipset_model (
  input  wire logic clk,              // Bus reference clock
  output logic      sys_mgmt_irq_n,   // Management request, active low
  output logic      clock_stop_req_n  // Clock-stop request, active low
);
  // Both requests idle high so nothing is seen at reset release
  initial begin
    sys_mgmt_irq_n   = 1'b1;
    clock_stop_req_n = 1'b1;
  end

  // management request drive
  // Edge-aligned change; the design still treats it as asynchronous
  task automatic set_mgmt(input logic lvl);
    @(posedge clk);
    sys_mgmt_irq_n <= lvl;
  endtask : set_mgmt

  // Clock-stop level, held as long as the bench asks
  task automatic set_stop(input logic lvl);
    @(posedge clk);
    clock_stop_req_n <= lvl;
  endtask : set_stop
endmodule : chipset_model

// >>> tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic                    clk = 1'b0, rst_n = 1'b0, temp_over = 1'b0;             // Bench-driven inputs
  logic                    save_done = 1'b0, ack_taken = 1'b0, mgmt_exit = 1'b0;   // Core-side handshakes
  logic                    sys_mgmt_irq_n, clock_stop_req_n;                       // From chipset model
  logic                    sys_mgmt_mode, state_save_req, handler_fetch;           // Sequencer outputs
  logic                    exec_halt, overtemp_trip_n;                             // Trip outputs
  pwr_state_pkg::ack_req_s ack_req;                                                // Acknowledge request
  pwr_state_pkg::clk_en_s  unit_clk_en;                                            // Clock enables
  int                      n_mismatch, cmp_count, k;                               // Counters
  int                      seed = 32'h9EC8;                                        // Fixed seed

  // Free-running 50 MHz bench clock
  always #10 clk = ~clk;

  chipset_model chipset_model_i (.clk(clk), .sys_mgmt_irq_n(sys_mgmt_irq_n), .clock_stop_req_n(clock_stop_req_n));
  pwr_state_ctl pwr_state_ctl_i (.clk(clk), .rst_n(rst_n), .sys_mgmt_irq_n(sys_mgmt_irq_n),
    .clock_stop_req_n(clock_stop_req_n), .temp_over(temp_over), .save_done(save_done), .ack_taken(ack_taken),
    .mgmt_exit(mgmt_exit), .sys_mgmt_mode(sys_mgmt_mode), .state_save_req(state_save_req), .ack_req(ack_req),
    .handler_fetch(handler_fetch), .unit_clk_en(unit_clk_en), .exec_halt(exec_halt),
    .overtemp_trip_n(overtemp_trip_n));

  // Bit compare, four-state safe
  task automatic chk(input string what, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s exp %b got %b", what, exp, got);
    end
  endtask : chk
  // Acknowledge request compare
  task automatic chk_ack(input pwr_state_pkg::ack_req_s exp);
    cmp_count++;
    if (ack_req !== exp) begin
      n_mismatch++;
      $display("BAD ack_req exp %b got %b", exp, ack_req);
    end
  endtask : chk_ack
  // Bus and interrupt units must never lose their clock
  task automatic chk_clk(input logic core);
    pwr_state_pkg::clk_en_s exp;
    exp = '{core: core, bus: 1'b1, apic: 1'b1};
    cmp_count++;
    if (unit_clk_en !== exp) begin
      n_mismatch++;
      $display("BAD unit_clk_en exp %b got %b", exp, unit_clk_en);
    end
  endtask : chk_clk

  function automatic pwr_state_pkg::ack_req_s exp_ack(input pwr_state_pkg::ack_kind_e kind);
    return '{valid: 1'b1, kind: kind};
  endfunction : exp_ack
  function automatic int rnd(input int lo, input int span);
    return lo + int'($unsigned($random(seed)) % span);
  endfunction : rnd

  // Sample just after the edge so its updates have landed
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic do_reset();
    @(posedge clk); rst_n <= 1'b0;
    tick(3);
    @(posedge clk); rst_n <= 1'b1;
  endtask : do_reset

  // Random levels on the core-side handshakes outside their states must change nothing
  task automatic idle_noise(input int n);
    repeat (n) begin
      @(posedge clk);
      save_done <= 1'($random(seed));
      ack_taken <= 1'($random(seed));
      mgmt_exit <= 1'($random(seed));
    end
    @(posedge clk);
    save_done <= 1'b0;
    ack_taken <= 1'b0;
    mgmt_exit <= 1'b0;
    #1;
    chk("state_save_req", 1'b0, state_save_req);
    chk("sys_mgmt_mode", 1'b0, sys_mgmt_mode);
    chk("ack_req.valid", 1'b0, ack_req.valid);
    chk("handler_fetch", 1'b0, handler_fetch);
  endtask : idle_noise

  task automatic mgmt_seq(input bit with_stop);
    chipset_model_i.set_mgmt(1'b0);
    tick(3); chk("state_save_req", 1'b0, state_save_req);
    tick(1); chk("state_save_req", 1'b1, state_save_req);
    chk("sys_mgmt_mode", 1'b0, sys_mgmt_mode);
    tick(rnd(0, 4)); chk("state_save_req", 1'b1, state_save_req);
    @(posedge clk); save_done <= 1'b1;
    @(posedge clk); save_done <= 1'b0; #1;
    chk("sys_mgmt_mode", 1'b1, sys_mgmt_mode);
    chk_ack(exp_ack(pwr_state_pkg::ACK_SMM));
    chk("handler_fetch", 1'b0, handler_fetch);
    chipset_model_i.set_mgmt(1'b1);
    tick(rnd(0, 3)); chk_ack(exp_ack(pwr_state_pkg::ACK_SMM));
    @(posedge clk); ack_taken <= 1'b1;
    @(posedge clk); ack_taken <= 1'b0; #1;
    chk("ack_req.valid", 1'b0, ack_req.valid);
    chk("handler_fetch", 1'b1, handler_fetch);
    tick(1); chk("handler_fetch", 1'b0, handler_fetch);
    if (with_stop) begin
      // Clock-stop inside the handler must return to the handler
      stop_seq();
      chk("sys_mgmt_mode", 1'b1, sys_mgmt_mode);
    end
    @(posedge clk); mgmt_exit <= 1'b1;
    @(posedge clk); mgmt_exit <= 1'b0; #1;
    chk("sys_mgmt_mode", 1'b0, sys_mgmt_mode);
  endtask : mgmt_seq

  task automatic stop_seq();
    chipset_model_i.set_stop(1'b0);
    tick(2); chk("ack_req.valid", 1'b0, ack_req.valid);
    tick(1); chk_ack(exp_ack(pwr_state_pkg::ACK_STOPGRANT));
    tick(rnd(0, 3)); chk_clk(1'b1);
    @(posedge clk); ack_taken <= 1'b1;
    @(posedge clk); ack_taken <= 1'b0; #1;
    chk("ack_req.valid", 1'b0, ack_req.valid);
    chk_clk(1'b0);
    tick(rnd(1, 6)); chk_clk(1'b0);
    chipset_model_i.set_stop(1'b1);
    tick(2); chk_clk(1'b0);
    tick(1); chk_clk(1'b1);
  endtask : stop_seq

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  // Watchdog well past the expected run of a few hundred cycles
  initial begin
    #200000;
    n_mismatch++;
    end_sim();
  end

  // Main sequence
  initial begin
    tick(3);
    @(posedge clk); rst_n <= 1'b1;
    tick(4); chk("overtemp_trip_n", 1'b1, overtemp_trip_n);
    for (k = 0; k < 8; k++) begin
      if (rnd(0, 2) == 0) mgmt_seq(rnd(0, 2) == 0);
      else stop_seq();
      idle_noise(rnd(3, 4));
    end
    @(posedge clk); temp_over <= 1'b1;
    tick(2); chk("overtemp_trip_n", 1'b1, overtemp_trip_n);
    tick(1); chk("overtemp_trip_n", 1'b0, overtemp_trip_n);
    chk("exec_halt", 1'b1, exec_halt);
    chk_clk(1'b0);
    @(posedge clk); temp_over <= 1'b0;
    chipset_model_i.set_mgmt(1'b0);
    tick(8); chk("overtemp_trip_n", 1'b0, overtemp_trip_n);
    chk("state_save_req", 1'b0, state_save_req);
    chk("exec_halt", 1'b1, exec_halt);
    chipset_model_i.set_mgmt(1'b1);
    do_reset();
    tick(4); chk("overtemp_trip_n", 1'b1, overtemp_trip_n);
    chk("exec_halt", 1'b0, exec_halt);
    mgmt_seq(1'b1);
    @(posedge clk); temp_over <= 1'b1;
    do_reset();
    tick(2); chk("overtemp_trip_n", 1'b1, overtemp_trip_n);
    tick(1); chk("overtemp_trip_n", 1'b0, overtemp_trip_n);
    chk("exec_halt", 1'b1, exec_halt);
    end_sim();
  end
endmodule : tb_top
